//--- rtl/rtc_cfg.svh
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// Register byte offsets
`define RTC_OFF_CTRL    5'h00
`define RTC_OFF_TIME    5'h04
`define RTC_OFF_ALARM0  5'h08
`define RTC_OFF_ALARM1  5'h0c
`define RTC_OFF_SWATCH  5'h10
`define RTC_OFF_STATUS  5'h14
`define RTC_OFF_WAKE    5'h18

// Event bit positions, shared by CTRL, STATUS and WAKE
`define RTC_EV_SEC      0
`define RTC_EV_MIN      1
`define RTC_EV_DAY      2
`define RTC_EV_AL0      3
`define RTC_EV_AL1      4
`define RTC_EV_SW       5
`define RTC_EV_N        6

// Time word field positions
`define RTC_F_SEC       0
`define RTC_F_MIN       8
`define RTC_F_HOUR      16
`define RTC_F_DAY       24

// Wrap limits
`define RTC_SEC_LAST    6'h3b
`define RTC_MIN_LAST    6'h3b
`define RTC_HOUR_LAST   5'h17

// Reset values
`define RTC_CTRL_RST    6'h00
`define RTC_WAKE_RST    6'h00
`define RTC_ALARM_RST   32'h0000_0000

// Timing
`define RTC_XTAL_HZ     32768
`define RTC_SW_W        16

`endif

//--- rtl/rtc_pkg.sv
`default_nettype none

package rtc_pkg;
  typedef logic [5:0] rtc_sec_t;
  typedef logic [5:0] rtc_min_t;
  typedef logic [4:0] rtc_hour_t;
  typedef logic [7:0] rtc_day_t;
  typedef logic [5:0] rtc_ev_t;
endpackage

`default_nettype wire

//--- rtl/rtc_alarm_stopwatch.sv
// Notes on behaviour
// - Time base is the external 32.768 kHz crystal; never gated by low power.
// - Prescaler divides crystal edges down to a one-per-second tick.
// - Seconds and minutes counters are six bits wide.
// - Hours counter is five bits, day counter eight bits.
// - Enabled alarm flags an interrupt when counters equal the alarm value.
// - Alarm 0 matches time of day; alarm 1 matches day plus time.
// - Stopwatch loads a programmed value and counts down once per minute.
// - Enabled stopwatch flags an interrupt on countdown underflow.
// - Second, minute and day tick interrupts are separately enabled.
// - Any clock interrupt can drive the wakeup output.
// - A per-source wakeup enable decides which interrupts wake the processor.
`include "rtc_cfg.svh"
`default_nettype none

module rtc_alarm_stopwatch #(
  parameter int PRESCALE_DIV = `RTC_XTAL_HZ,
  parameter int SW_W         = `RTC_SW_W
) (
  // Clock and reset
  input  wire  logic        clk_i,
  input  wire  logic        rst_i,
  // Crystal pin, asynchronous
  input  wire  logic        xtal_i,
  // Wishbone classic slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [4:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output var   logic [31:0] wb_dat_o,
  output var   logic        wb_ack_o,
  // Interrupt and wakeup
  output var   logic        irq_o,
  output var   logic        wake_o
);

  localparam int PW = $clog2(PRESCALE_DIV);
  localparam logic [PW-1:0] PRES_LAST = PW'(PRESCALE_DIV - 1);
  localparam logic [SW_W-1:0] SW_ZERO = '0;

  function automatic logic [31:0] pack_time(input rtc_pkg::rtc_sec_t  s,
                                            input rtc_pkg::rtc_min_t  m,
                                            input rtc_pkg::rtc_hour_t h,
                                            input rtc_pkg::rtc_day_t  d);
    logic [31:0] w;
    w = '0;
    w[`RTC_F_SEC  +: 6] = s;
    w[`RTC_F_MIN  +: 6] = m;
    w[`RTC_F_HOUR +: 5] = h;
    w[`RTC_F_DAY  +: 8] = d;
    return w;
  endfunction

  // One-hot register select, shared by the write strobes and the read mux
  function automatic logic [6:0] reg_hit(input logic [4:0] adr);
    logic [6:0] hit;
    hit = 7'h00;
    unique case (adr)
      `RTC_OFF_CTRL:   hit[0] = 1'b1;
      `RTC_OFF_TIME:   hit[1] = 1'b1;
      `RTC_OFF_ALARM0: hit[2] = 1'b1;
      `RTC_OFF_ALARM1: hit[3] = 1'b1;
      `RTC_OFF_SWATCH: hit[4] = 1'b1;
      `RTC_OFF_STATUS: hit[5] = 1'b1;
      `RTC_OFF_WAKE:   hit[6] = 1'b1;
      default:         hit = 7'h00;
    endcase
    return hit;
  endfunction

  // Crystal synchroniser and edge detect
  logic xtal_meta;
  logic xtal_sync;
  logic xtal_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_meta <= 1'b0;
      xtal_sync <= 1'b0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_meta <= xtal_i;
      xtal_sync <= xtal_meta;
      xtal_prev <= xtal_sync;
    end
  end

  // State
  logic [PW-1:0]        pres;
  rtc_pkg::rtc_sec_t    sec;
  rtc_pkg::rtc_min_t    min;
  rtc_pkg::rtc_hour_t   hour;
  rtc_pkg::rtc_day_t    day;
  logic [31:0]          alarm0;
  logic [31:0]          alarm1;
  logic [SW_W-1:0]      swatch;
  rtc_pkg::rtc_ev_t     ctrl;
  rtc_pkg::rtc_ev_t     status;
  rtc_pkg::rtc_ev_t     wake_en;

  logic [PW-1:0]        next_pres;
  rtc_pkg::rtc_sec_t    next_sec;
  rtc_pkg::rtc_min_t    next_min;
  rtc_pkg::rtc_hour_t   next_hour;
  rtc_pkg::rtc_day_t    next_day;
  logic [31:0]          next_alarm0;
  logic [31:0]          next_alarm1;
  logic [SW_W-1:0]      next_swatch;
  rtc_pkg::rtc_ev_t     next_ctrl;
  rtc_pkg::rtc_ev_t     next_status;
  rtc_pkg::rtc_ev_t     next_wake_en;
  logic [31:0]          next_dat;
  logic                 next_ack;
  logic                 next_irq;
  logic                 next_wake;

  logic                 xtal_tick;
  logic                 sec_tick;
  logic                 min_carry;
  logic                 hour_carry;
  logic                 day_carry;
  logic                 wr;
  rtc_pkg::rtc_ev_t     raw_ev;
  rtc_pkg::rtc_ev_t     clr;
  logic [31:0]          now_word;
  logic [6:0]           hit;
  logic                 wr_ctrl;
  logic [3:0]           wr_time;
  logic                 wr_al0;
  logic                 wr_al1;
  logic                 wr_sw;
  logic                 wr_wake;

  // Bus decode: a write lands on the edge where ack is seen high
  always_comb begin
    hit     = reg_hit(wb_adr_i);
    wr      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    wr_ctrl = wr && hit[0] && wb_sel_i[0];
    wr_time = (wr && hit[1]) ? wb_sel_i : 4'h0;
    wr_al0  = wr && hit[2];
    wr_al1  = wr && hit[3];
    wr_sw   = wr && hit[4];
    clr     = (wr && hit[5] && wb_sel_i[0]) ? wb_dat_i[5:0] : 6'h00;
    wr_wake = wr && hit[6] && wb_sel_i[0];
  end

  // Timekeeping group
  always_comb begin
    // Crystal edge counts in the fast domain, so the 10 MHz clock must stay up
    xtal_tick  = xtal_sync & ~xtal_prev;
    sec_tick   = xtal_tick && (pres == PRES_LAST);
    min_carry  = sec_tick && (sec == `RTC_SEC_LAST);
    hour_carry = min_carry && (min == `RTC_MIN_LAST);
    day_carry  = hour_carry && (hour == `RTC_HOUR_LAST);

    next_pres = pres;
    if (xtal_tick) begin
      next_pres = sec_tick ? '0 : pres + PW'(1);
    end

    next_sec  = sec;
    next_min  = min;
    next_hour = hour;
    next_day  = day;
    if (sec_tick) begin
      next_sec = min_carry ? 6'h00 : sec + 6'h01;
    end
    if (min_carry) begin
      next_min = hour_carry ? 6'h00 : min + 6'h01;
    end
    if (hour_carry) begin
      next_hour = day_carry ? 5'h00 : hour + 5'h01;
    end
    if (day_carry) begin
      next_day = day + 8'h01;
    end

    // Software write wins; setting seconds restarts the prescaler for a full second
    if (wr_time[0]) begin
      next_sec  = wb_dat_i[`RTC_F_SEC +: 6];
      next_pres = '0;
    end
    if (wr_time[1]) begin
      next_min = wb_dat_i[`RTC_F_MIN +: 6];
    end
    if (wr_time[2]) begin
      next_hour = wb_dat_i[`RTC_F_HOUR +: 5];
    end
    if (wr_time[3]) begin
      next_day = wb_dat_i[`RTC_F_DAY +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pres <= '0;
      sec  <= '0;
      min  <= '0;
      hour <= '0;
      day  <= '0;
    end else begin
      pres <= next_pres;
      sec  <= next_sec;
      min  <= next_min;
      hour <= next_hour;
      day  <= next_day;
    end
  end

  // Configuration group: alarms, stopwatch, enables
  always_comb begin
    next_swatch  = swatch;
    next_ctrl    = ctrl;
    next_alarm0  = alarm0;
    next_alarm1  = alarm1;
    next_wake_en = wake_en;
    if (min_carry && ctrl[`RTC_EV_SW]) begin
      if (swatch == SW_ZERO) begin
        next_ctrl[`RTC_EV_SW] = 1'b0;
      end else begin
        next_swatch = swatch - SW_W'(1);
      end
    end
    if (wr_ctrl) begin
      next_ctrl = wb_dat_i[5:0];
    end
    if (wr_al0) begin
      next_alarm0 = pack_time(wb_dat_i[`RTC_F_SEC +: 6], wb_dat_i[`RTC_F_MIN +: 6],
                              wb_dat_i[`RTC_F_HOUR +: 5], 8'h00);
    end
    if (wr_al1) begin
      next_alarm1 = pack_time(wb_dat_i[`RTC_F_SEC +: 6], wb_dat_i[`RTC_F_MIN +: 6],
                              wb_dat_i[`RTC_F_HOUR +: 5], wb_dat_i[`RTC_F_DAY +: 8]);
    end
    if (wr_sw) begin
      next_swatch = wb_dat_i[SW_W-1:0];
    end
    if (wr_wake) begin
      next_wake_en = wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm0  <= `RTC_ALARM_RST;
      alarm1  <= `RTC_ALARM_RST;
      swatch  <= '0;
      ctrl    <= `RTC_CTRL_RST;
      wake_en <= `RTC_WAKE_RST;
    end else begin
      alarm0  <= next_alarm0;
      alarm1  <= next_alarm1;
      swatch  <= next_swatch;
      ctrl    <= next_ctrl;
      wake_en <= next_wake_en;
    end
  end

  // Event group
  always_comb begin
    // Alarms compare against the value the counters take on this tick
    now_word = pack_time(next_sec, next_min, next_hour, next_day);
    raw_ev = '0;
    raw_ev[`RTC_EV_SEC] = sec_tick;
    raw_ev[`RTC_EV_MIN] = min_carry;
    raw_ev[`RTC_EV_DAY] = day_carry;
    raw_ev[`RTC_EV_AL0] = sec_tick && (now_word[23:0] == alarm0[23:0]);
    raw_ev[`RTC_EV_AL1] = sec_tick && (now_word == alarm1);
    raw_ev[`RTC_EV_SW]  = min_carry && ctrl[`RTC_EV_SW] && (swatch == SW_ZERO);
    // Set wins over a clear in the same cycle
    next_status = (status & ~clr) | (raw_ev & ctrl);
    next_irq    = |next_status;
    next_wake   = |(next_status & next_wake_en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
      irq_o  <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      status <= next_status;
      irq_o  <= next_irq;
      wake_o <= next_wake;
    end
  end

  // Bus reply group: registered ack, one wait state, then drop for a cycle
  always_comb begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = '0;
    if (next_ack && !wb_we_i) begin
      if (hit[0]) begin
        next_dat = {26'h0, ctrl};
      end else if (hit[1]) begin
        next_dat = pack_time(sec, min, hour, day);
      end else if (hit[2]) begin
        next_dat = alarm0;
      end else if (hit[3]) begin
        next_dat = alarm1;
      end else if (hit[4]) begin
        next_dat = 32'(swatch);
      end else if (hit[5]) begin
        next_dat = {26'h0, status};
      end else if (hit[6]) begin
        next_dat = {26'h0, wake_en};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
      wb_ack_o <= 1'b0;
    end else begin
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
    end
  end

endmodule // rtc_alarm_stopwatch

`default_nettype wire

//--- verif/rtc_alarm_stopwatch_asserts.sv
`include "rtc_cfg.svh"
`default_nettype none

module rtc_alarm_stopwatch_asserts (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Watched pins
  input wire logic        xtal_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        irq_o,
  input wire logic        wake_o
);
  logic       xtal_q;
  logic       next_xtal_q;
  logic [3:0] since;
  logic [3:0] next_since;
  logic       st_wr;
  logic       wk_wr;
  assign st_wr = wb_ack_o && wb_we_i && wb_adr_i == `RTC_OFF_STATUS;
  assign wk_wr = wb_ack_o && wb_we_i && wb_adr_i == `RTC_OFF_WAKE;
  // Cycles since a raw crystal rise; saturates so it never wraps
  always_comb begin
    next_xtal_q = xtal_i;
    next_since  = (since == 4'hf) ? since : since + 4'h1;
    if (xtal_i && !xtal_q)
      next_since = 4'h0;
    if (rst_i)
      next_since = 4'hf;
  end
  always_ff @(posedge clk_i) begin
    xtal_q <= next_xtal_q;
    since  <= next_since;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !irq_o && !wake_o && !wb_ack_o)
    else $error("outputs active after reset");
  chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i))
    else $error("ack without request");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 5'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_wake_subset: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt");
  chk_irq_from_tick: assert property ($rose(irq_o) |-> since <= 4'h8)
    else $error("interrupt without crystal tick");
  chk_irq_clear: assert property ($fell(irq_o) |-> $past(st_wr))
    else $error("interrupt dropped without clear");
  chk_wake_clear: assert property ($fell(wake_o) |-> $past(st_wr) || $past(wk_wr))
    else $error("wake dropped without clear");
  cover property (st_wr);
  cover property ($rose(irq_o));
  cover property ($rose(wake_o));
endmodule // rtc_alarm_stopwatch_asserts

bind rtc_alarm_stopwatch rtc_alarm_stopwatch_asserts rtc_alarm_stopwatch_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .wake_o(wake_o));

`default_nettype wire

//--- verif/rtc_xtal_model.sv
`default_nettype none

module rtc_xtal_model (
  // Half period in ns
  input wire logic [15:0] half_ns_i,
  // Crystal square wave
  output var logic        xtal_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free running, never stopped by low power; odd start keeps it off the clock phase
  initial begin
    xtal_o = 1'b0;
    #37;
    forever begin
      #(half_ns_i) xtal_o = ~xtal_o;
    end
  end
endmodule // rtc_xtal_model

`default_nettype wire

//--- verif/test_rtc_alarm_stopwatch.sv
`include "rtc_cfg.svh"
`default_nettype none

module test_rtc_alarm_stopwatch;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        xtal_i;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        irq_o;
  logic        wake_o;
  logic [15:0] half_ns = 16'd400;
  logic [31:0] rnd = 32'd96446;
  logic [31:0] rd;
  int          failures = 0;
  int          n_compared = 0;
  time         t0;
  logic [4:0]  offs [7] = '{`RTC_OFF_CTRL, `RTC_OFF_TIME, `RTC_OFF_ALARM0, `RTC_OFF_ALARM1,
                           `RTC_OFF_SWATCH, `RTC_OFF_STATUS, 5'h1c};

  always #50 clk_i = ~clk_i;

  rtc_xtal_model rtc_xtal_model_inst (.half_ns_i(half_ns), .xtal_o(xtal_i));
  rtc_alarm_stopwatch #(.PRESCALE_DIV(4)) rtc_alarm_stopwatch_inst (
    .clk_i(clk_i), .rst_i(rst_i), .xtal_i(xtal_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .wake_o(wake_o));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] tword(input logic [7:0] d, h, m, s);
    return {d, h, m, s};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      failures++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 4'hf);
  endtask
  task automatic rdchk(input logic [4:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0, 4'hf);
    chk(rd, exp);
  endtask
  // Wait to mid-second so crystal phase jitter cannot move the result
  task automatic at_sec(input int n);
    #(t0 + n * 8 * half_ns + 4 * half_ns - $time);
    @(posedge clk_i);
  endtask
  task automatic settime(input logic [31:0] w, input logic [3:0] sel);
    bus(1'b1, `RTC_OFF_TIME, w, sel);
    t0 = $time;
  endtask
  task automatic minute;
    settime(32'h3b, 4'h1);
    at_sec(1);
  endtask
  task automatic wrap_up;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #1_000_000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (offs[i])
      rdchk(offs[i], 32'h0);
    rnd = lfsr(rnd);
    wr(5'h1c, rnd);
    rdchk(5'h1c, 32'h0);
    wr(`RTC_OFF_TIME, 32'hffffffff);
    rdchk(`RTC_OFF_TIME, 32'hff1f3f3f);
    wr(`RTC_OFF_CTRL, 32'h7);
    settime(tword(8'h05, 8'h17, 8'h3b, 8'h3a), 4'hf);
    at_sec(2);
    rdchk(`RTC_OFF_TIME, tword(8'h06, 8'h00, 8'h00, 8'h00));
    rdchk(`RTC_OFF_STATUS, 32'h7);
    chk({30'h0, irq_o, wake_o}, 32'h2);
    wr(`RTC_OFF_CTRL, 32'h18);
    wr(`RTC_OFF_STATUS, 32'h3f);
    wr(`RTC_OFF_WAKE, 32'h8);
    rnd = lfsr(rnd);
    wr(`RTC_OFF_ALARM0, {rnd[7:0], 24'h000003});
    wr(`RTC_OFF_ALARM1, tword(8'h06, 8'h00, 8'h00, 8'h04));
    rdchk(`RTC_OFF_ALARM0, 32'h3);
    settime(tword(8'h06, 8'h00, 8'h00, 8'h01), 4'hf);
    at_sec(1);
    rdchk(`RTC_OFF_STATUS, 32'h0);
    at_sec(2);
    rdchk(`RTC_OFF_STATUS, 32'h8);
    chk({31'h0, wake_o}, 32'h1);
    at_sec(3);
    rdchk(`RTC_OFF_STATUS, 32'h18);
    wr(`RTC_OFF_STATUS, 32'h8);
    rdchk(`RTC_OFF_STATUS, 32'h10);
    chk({30'h0, irq_o, wake_o}, 32'h2);
    half_ns = 16'd500;
    wr(`RTC_OFF_CTRL, 32'h0);
    wr(`RTC_OFF_STATUS, 32'h3f);
    rnd = lfsr(rnd);
    wr(`RTC_OFF_SWATCH, rnd);
    rdchk(`RTC_OFF_SWATCH, {16'h0, rnd[15:0]});
    wr(`RTC_OFF_SWATCH, 32'h1);
    wr(`RTC_OFF_CTRL, 32'h20);
    minute();
    rdchk(`RTC_OFF_SWATCH, 32'h0);
    rdchk(`RTC_OFF_STATUS, 32'h0);
    minute();
    rdchk(`RTC_OFF_STATUS, 32'h20);
    rdchk(`RTC_OFF_CTRL, 32'h0);
    wr(`RTC_OFF_STATUS, 32'h3f);
    minute();
    rdchk(`RTC_OFF_STATUS, 32'h0);
    wrap_up();
  end
endmodule // test_rtc_alarm_stopwatch

`default_nettype wire
